// File: ofp_afe_model.sv
// behavioural analog comparator front end for the protection block
`timescale 1ns/1ps
`default_nettype none
module ofp_afe_model #(
  parameter integer NCH     = 2,
  parameter integer WARN_LO = 115,
  parameter integer WARN_HI = 135,
  parameter integer SHUT    = 170,
  parameter integer DIE_LIM = 63
) (
  input  wire logic [7:0]       i_die_temp,
  input  wire logic [8*NCH-1:0] i_temp,
  input  wire logic [2*NCH-1:0] i_load,
  output logic                  o_die_hot,
  output logic [NCH-1:0]        o_warn_lo,
  output logic [NCH-1:0]        o_warn_hi,
  output logic [NCH-1:0]        o_shutdown_temp,
  output logic [NCH-1:0]        o_over_inrush,
  output logic [NCH-1:0]        o_over_steady
);
  // levels are asynchronous to the block clock, as real comparators are
  always_comb begin
    o_die_hot = i_die_temp > DIE_LIM;
    for (int c = 0; c < NCH; c++) begin
      o_warn_lo[c]       = i_temp[8*c +: 8] > WARN_LO;
      o_warn_hi[c]       = i_temp[8*c +: 8] > WARN_HI;
      o_shutdown_temp[c] = i_temp[8*c +: 8] > SHUT;
      o_over_steady[c]   = i_load[2*c +: 2] >= 2'h1;
      o_over_inrush[c]   = i_load[2*c +: 2] >= 2'h2;
    end
  end
endmodule // ofp_afe_model
`default_nettype wire

// File: ofp_channel.v
// one output channel: inrush windows, thermal stages, autorestart
`timescale 1ns/1ps
`default_nettype none
`include "ofp_defines.vh"

module ofp_channel #(
  parameter integer WIN1_CYC     = `OFP_CYC(`OFP_T_WIN1_US),
  parameter integer WIN2_CYC     = `OFP_CYC(`OFP_T_WIN2_US),
  parameter integer WIN3_CYC     = `OFP_CYC(`OFP_T_WIN3_US),
  parameter integer RESTART_CYC  = `OFP_CYC(`OFP_T_RESTART_US),
  parameter integer DEGLITCH_CYC = `OFP_CYC(`OFP_T_DEGLITCH_US)
) (
  input  wire       i_clk,
  input  wire       i_rst,
  input  wire       i_on_cmd,
  input  wire       i_on_rise,
  input  wire       i_short_win,
  input  wire       i_fail_mode,
  input  wire       i_blank,
  input  wire       i_over_inrush,
  input  wire       i_over_steady,
  input  wire       i_warn_hi,
  input  wire       i_warn_lo,
  input  wire       i_warn_sel,
  input  wire       i_shutdown_temp,
  input  wire       i_status_read,
  output reg        o_out_en,
  output reg  [1:0] o_phase,
  output reg        o_warn_flag,
  output reg        o_sd_flag,
  output reg        o_oc_flag
);

  reg  [`OFP_CNT_W-1:0] win_cnt_reg;
  reg  [`OFP_CNT_W-1:0] rst_cnt_reg;
  reg  [7:0]            dgl_cnt_reg;
  reg                   restart_wait_reg;
  reg                   latch_off_reg;
  wire                  warn_now;
  wire [`OFP_CNT_W-1:0] win_len;
  wire                  win_done;
  wire                  overcur;

  // -------------------------------------------------------------
  // window length for the current phase
  // -------------------------------------------------------------
  assign win_len = (o_phase == `OFP_PH_WIN1) ? WIN1_CYC[`OFP_CNT_W-1:0] :
                   (o_phase == `OFP_PH_WIN2) ? WIN2_CYC[`OFP_CNT_W-1:0] :
                                               WIN3_CYC[`OFP_CNT_W-1:0];
  // shortened option halves every window
  assign win_done = (win_cnt_reg + 21'h000001) >=
                    (i_short_win ? (win_len >> 1) : win_len);
  assign warn_now = i_warn_sel ? i_warn_lo : i_warn_hi;
  assign overcur  = (o_phase == `OFP_PH_IDLE) ? i_over_steady : i_over_inrush;

  always @(posedge i_clk) begin
    if (i_rst) begin
      win_cnt_reg      <= 21'h000000;
      rst_cnt_reg      <= 21'h000000;
      dgl_cnt_reg      <= 8'h00;
      restart_wait_reg <= 1'b0;
      latch_off_reg    <= 1'b0;
      o_out_en         <= 1'b0;
      o_phase          <= `OFP_PH_IDLE;
      o_warn_flag      <= 1'b0;
      o_sd_flag        <= 1'b0;
      o_oc_flag        <= 1'b0;
    end else begin
      // -----------------------------------------------------------
      // inrush windows
      // -----------------------------------------------------------
      if (i_on_rise) begin
        o_phase     <= `OFP_PH_WIN1;
        win_cnt_reg <= 21'h000000;
      end else if (o_phase != `OFP_PH_IDLE && i_on_cmd && !o_sd_flag) begin
        if (win_done) begin
          win_cnt_reg <= 21'h000000;
          case (o_phase)
            `OFP_PH_WIN1: o_phase <= `OFP_PH_WIN2;
            `OFP_PH_WIN2: o_phase <= `OFP_PH_WIN3;
            default:      o_phase <= `OFP_PH_IDLE;
          endcase
        end else begin
          win_cnt_reg <= win_cnt_reg + 21'h000001;
        end
      end

      // -----------------------------------------------------------
      // thermal: warning keeps output state, shutdown after deglitch
      // -----------------------------------------------------------
      if (i_shutdown_temp && !i_blank) begin
        if (dgl_cnt_reg + 8'h01 >= DEGLITCH_CYC[7:0]) begin
          o_sd_flag     <= 1'b1;
          latch_off_reg <= 1'b1;
        end else begin
          dgl_cnt_reg <= dgl_cnt_reg + 8'h01;
        end
      end else begin
        dgl_cnt_reg <= 8'h00;
      end
      // set wins over clear; clear needs cool-down and a read
      if (warn_now && !i_blank)
        o_warn_flag <= 1'b1;
      else if (i_status_read)
        o_warn_flag <= 1'b0;
      if (i_status_read && !i_shutdown_temp && !(i_shutdown_temp && !i_blank))
        o_sd_flag <= 1'b0;

      // -----------------------------------------------------------
      // overcurrent and fail-mode autorestart
      // -----------------------------------------------------------
      if (overcur && !i_blank && o_out_en) begin
        o_oc_flag <= 1'b1;
        if (i_fail_mode && o_phase != `OFP_PH_WIN1) begin
          restart_wait_reg <= 1'b1;
          rst_cnt_reg      <= 21'h000000;
        end else begin
          latch_off_reg <= 1'b1;
        end
      end else if (i_status_read) begin
        o_oc_flag <= 1'b0;
      end
      if (restart_wait_reg) begin
        if (rst_cnt_reg + 21'h000001 >= RESTART_CYC[`OFP_CNT_W-1:0]) begin
          restart_wait_reg <= 1'b0;
          o_phase          <= `OFP_PH_WIN1;
          win_cnt_reg      <= 21'h000000;
        end else begin
          rst_cnt_reg <= rst_cnt_reg + 21'h000001;
        end
      end
      // a fresh turn-on command releases a latched fault unless shutdown temperature is still present
      if (i_on_rise && !i_shutdown_temp)
        latch_off_reg <= 1'b0;
      o_out_en <= i_on_cmd && !latch_off_reg && !restart_wait_reg &&
                  !(overcur && !i_blank && o_out_en) && !(o_sd_flag);
    end
  end

endmodule // ofp_channel

`default_nettype wire

// File: ofp_chk_assertions.sv
// concurrent checks on the ports of the protection top
`timescale 1ns/1ps
`default_nettype none
module ofp_chk #(
  parameter integer NCH          = 5,
  parameter integer BLANK_CYC    = 1000,
  parameter integer DEGLITCH_CYC = 40
) (
  input wire logic             I_CLK,
  input wire logic             I_RST,
  input wire logic             i_thermal_adjust_bit,
  input wire logic             i_transient_adjust_bit,
  input wire logic             i_warning_threshold_select,
  input wire logic             i_die_hot,
  input wire logic [NCH-1:0]   i_channel_on_command,
  input wire logic [NCH-1:0]   i_status_read,
  input wire logic [NCH-1:0]   i_out_below_half,
  input wire logic [NCH-1:0]   i_warn_hi,
  input wire logic [NCH-1:0]   i_warn_lo,
  input wire logic [NCH-1:0]   i_shutdown_temp,
  input wire logic [NCH-1:0]   o_out_en,
  input wire logic [NCH-1:0]   o_level_one_reduce,
  input wire logic [NCH-1:0]   o_level_halve,
  input wire logic [2*NCH-1:0] o_phase,
  input wire logic [NCH-1:0]   o_channel_temp_warning_flag,
  input wire logic [NCH-1:0]   o_thermal_shutdown,
  input wire logic             o_quick_temp_warning,
  input wire logic             o_blanking
);
  logic [15:0] sd_cnt_reg;
  logic [15:0] blank_cnt_reg;
  // ------------------------------------------------------------
  // run lengths; raw pin is counted so sync latency only adds
  // ------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      sd_cnt_reg    <= 16'h0000;
      blank_cnt_reg <= 16'h0000;
    end else begin
      sd_cnt_reg    <= i_shutdown_temp[0] ? sd_cnt_reg + 16'h0001 : 16'h0000;
      blank_cnt_reg <= o_blanking ? blank_cnt_reg + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  AST_THERM_OFF: assert property ((!i_thermal_adjust_bit) [*5] |-> o_level_one_reduce == '0)
    else $error("level one cut without thermal adjust");
  AST_THERM_ON: assert property ((i_thermal_adjust_bit && i_die_hot) [*6] |-> o_level_one_reduce[0])
    else $error("level one not cut on hot die");
  AST_TRANS_OFF: assert property ((!i_transient_adjust_bit) [*5] |-> o_level_halve == '0)
    else $error("halving without transient adjust");
  AST_TRANS_HALF: assert property (
    (i_transient_adjust_bit && i_out_below_half[0] && i_channel_on_command[0] && o_phase[1:0] != 2'h0) [*6]
    |-> o_level_halve[0]) else $error("no halving below half supply");
  AST_WARN_SET: assert property (
    (!o_blanking && (i_warning_threshold_select ? i_warn_lo[0] : i_warn_hi[0])) [*6]
    |-> o_channel_temp_warning_flag[0]) else $error("warning not flagged");
  AST_QUICK: assert property (o_channel_temp_warning_flag[0] |-> ##[0:1] o_quick_temp_warning)
    else $error("quick warning missing");
  AST_WARN_KEEP: assert property (
    $rose(o_channel_temp_warning_flag[0]) && !o_thermal_shutdown[0] |-> $stable(o_out_en[0]))
    else $error("warning changed output");
  AST_WARN_HOLD: assert property ($fell(o_channel_temp_warning_flag[0]) |->
    $past(i_status_read[0]) || $past(i_status_read[0], 2) || $past(i_status_read[0], 3))
    else $error("warning cleared without read");
  AST_SD: assert property (
    $rose(o_thermal_shutdown[0]) |-> sd_cnt_reg >= DEGLITCH_CYC ##[0:1] !o_out_en[0])
    else $error("shutdown before deglitch or output left on");
  AST_BLANK: assert property (o_blanking |-> blank_cnt_reg <= BLANK_CYC)
    else $error("blanking too long");
  AST_FREEZE: assert property ((!i_channel_on_command[0]) [*3] |-> $stable(o_phase[1:0]))
    else $error("window advanced while off");
  cover property ($rose(o_thermal_shutdown[0]));
  cover property ($fell(o_channel_temp_warning_flag[0]));
  cover property (o_phase[1:0] == 2'h3 ##1 o_phase[1:0] == 2'h0);
endmodule // ofp_chk

bind ofp_top ofp_chk #(.NCH(NCH), .BLANK_CYC(BLANK_CYC), .DEGLITCH_CYC(DEGLITCH_CYC)) u_chk (
  .I_CLK(I_CLK), .I_RST(I_RST), .i_thermal_adjust_bit(i_thermal_adjust_bit),
  .i_transient_adjust_bit(i_transient_adjust_bit), .i_warning_threshold_select(i_warning_threshold_select),
  .i_die_hot(i_die_hot), .i_channel_on_command(i_channel_on_command), .i_status_read(i_status_read),
  .i_out_below_half(i_out_below_half), .i_warn_hi(i_warn_hi), .i_warn_lo(i_warn_lo),
  .i_shutdown_temp(i_shutdown_temp), .o_out_en(o_out_en), .o_level_one_reduce(o_level_one_reduce),
  .o_level_halve(o_level_halve), .o_phase(o_phase), .o_channel_temp_warning_flag(o_channel_temp_warning_flag),
  .o_thermal_shutdown(o_thermal_shutdown), .o_quick_temp_warning(o_quick_temp_warning), .o_blanking(o_blanking));
`default_nettype wire

// File: ofp_defines.vh
// constants for the output fault protection logic
`ifndef OFP_DEFINES_VH
`define OFP_DEFINES_VH

`define OFP_CLK_KHZ        20000
// window and restart times in microseconds, nominal
`define OFP_T_WIN1_US      2000
`define OFP_T_WIN2_US      8000
`define OFP_T_WIN3_US      64000
`define OFP_T_RESTART_US   64000
// blanking 50 us typical, 100 us max; deglitch 2 us typical
`define OFP_T_BLANK_US     50
`define OFP_T_DEGLITCH_US  2
// derived cycle counts (rounded down, nominal values)
`define OFP_CYC(us)        ((us) * `OFP_CLK_KHZ / 1000)
`define OFP_CNT_W          21

// inrush phase codes
`define OFP_PH_IDLE        2'h0
`define OFP_PH_WIN1        2'h1
`define OFP_PH_WIN2        2'h2
`define OFP_PH_WIN3        2'h3

`endif

// File: ofp_top.v
// top of the output fault protection logic for all channels
// Operation
// - thermal bit and hot die cut level 15%
// - thermal bit clear keeps default first level
// - transient bit halves levels below half supply, in inrush windows only
// - transient bit clear keeps default levels
// - first window 2 ms, short 1 ms
// - second window 8 ms, short 4 ms
// - third window 64 ms, short 32 ms
// - fail mode restart after 64 ms for faults outside the first window
// - blank faults 50 us after wake-up
// - per-channel warning and shutdown temperature stages
// - warning keeps output state, flags it
// - shutdown after deglitch, status after deglitch
// - warning shown in quick and channel status
// - select bit picks high or low warning
// - warning clears after cool-down and read
// - short bit halves every window
// - windows count only while on command
`timescale 1ns/1ps
`default_nettype none
`include "ofp_defines.vh"

module ofp_top #(
  parameter integer NCH          = 5,
  parameter integer WIN1_CYC     = `OFP_CYC(`OFP_T_WIN1_US),
  parameter integer WIN2_CYC     = `OFP_CYC(`OFP_T_WIN2_US),
  parameter integer WIN3_CYC     = `OFP_CYC(`OFP_T_WIN3_US),
  parameter integer RESTART_CYC  = `OFP_CYC(`OFP_T_RESTART_US),
  parameter integer BLANK_CYC    = `OFP_CYC(`OFP_T_BLANK_US),
  parameter integer DEGLITCH_CYC = `OFP_CYC(`OFP_T_DEGLITCH_US)
) (
  input  wire           I_CLK,
  input  wire           I_RST,
  input  wire           i_wake,
  input  wire           i_fail_mode,
  input  wire           i_thermal_adjust_bit,
  input  wire           i_transient_adjust_bit,
  input  wire           i_warning_threshold_select,
  input  wire [NCH-1:0] i_channel_on_command,
  input  wire [NCH-1:0] i_shortened_window_bit,
  input  wire [NCH-1:0] i_status_read,
  input  wire           i_die_hot,
  input  wire [NCH-1:0] i_out_below_half,
  input  wire [NCH-1:0] i_over_inrush,
  input  wire [NCH-1:0] i_over_steady,
  input  wire [NCH-1:0] i_warn_hi,
  input  wire [NCH-1:0] i_warn_lo,
  input  wire [NCH-1:0] i_shutdown_temp,
  output reg  [NCH-1:0] o_out_en,
  output reg  [NCH-1:0] o_level_one_reduce,
  output reg  [NCH-1:0] o_level_halve,
  output reg  [2*NCH-1:0] o_phase,
  output reg  [NCH-1:0] o_channel_temp_warning_flag,
  output reg  [NCH-1:0] o_thermal_shutdown,
  output reg  [NCH-1:0] o_overcurrent_flag,
  output reg            o_quick_temp_warning,
  output reg            o_blanking
);

  // -------------------------------------------------------------
  // pin synchronisers: comparator results come from the analog side
  // -------------------------------------------------------------
  localparam integer SW = 6 * NCH + 2;
  wire [SW-1:0] async_in;
  reg  [SW-1:0] sync1_reg;
  reg  [SW-1:0] sync2_reg;
  assign async_in = {i_wake, i_die_hot, i_out_below_half, i_over_inrush,
                     i_over_steady, i_warn_hi, i_warn_lo, i_shutdown_temp};

  always @(posedge I_CLK) begin
    if (I_RST) begin
      sync1_reg <= {SW{1'b0}};
      sync2_reg <= {SW{1'b0}};
    end else begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
    end
  end

  wire           s_wake     = sync2_reg[6*NCH+1];
  wire           s_hot      = sync2_reg[6*NCH];
  wire [NCH-1:0] s_below    = sync2_reg[5*NCH +: NCH];
  wire [NCH-1:0] s_inrush   = sync2_reg[4*NCH +: NCH];
  wire [NCH-1:0] s_steady   = sync2_reg[3*NCH +: NCH];
  wire [NCH-1:0] s_whi      = sync2_reg[2*NCH +: NCH];
  wire [NCH-1:0] s_wlo      = sync2_reg[NCH +: NCH];
  wire [NCH-1:0] s_sd       = sync2_reg[0 +: NCH];

  // -------------------------------------------------------------
  // wake-up blanking
  // -------------------------------------------------------------
  reg        wake_d_reg;
  reg [11:0] blank_cnt_reg;
  wire       blank_now = (blank_cnt_reg != 12'h000);

  always @(posedge I_CLK) begin
    if (I_RST) begin
      wake_d_reg    <= 1'b0;
      blank_cnt_reg <= 12'h000;
    end else begin
      wake_d_reg <= s_wake;
      if (s_wake && !wake_d_reg)
        blank_cnt_reg <= BLANK_CYC[11:0];
      else if (blank_now)
        blank_cnt_reg <= blank_cnt_reg - 12'h001;
    end
  end

  // -------------------------------------------------------------
  // on command edge detect (command is same-domain logic)
  // -------------------------------------------------------------
  reg  [NCH-1:0] on_d_reg;
  wire [NCH-1:0] on_rise = i_channel_on_command & ~on_d_reg;
  always @(posedge I_CLK) begin
    if (I_RST)
      on_d_reg <= {NCH{1'b0}};
    else
      on_d_reg <= i_channel_on_command;
  end

  // -------------------------------------------------------------
  // channels: each owns its windows and temperature stages
  // -------------------------------------------------------------
  wire [NCH-1:0]   ch_en;
  wire [2*NCH-1:0] ch_phase;
  wire [NCH-1:0]   ch_warn;
  wire [NCH-1:0]   ch_sd;
  wire [NCH-1:0]   ch_oc;

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      ofp_channel #(
        .WIN1_CYC     (WIN1_CYC),
        .WIN2_CYC     (WIN2_CYC),
        .WIN3_CYC     (WIN3_CYC),
        .RESTART_CYC  (RESTART_CYC),
        .DEGLITCH_CYC (DEGLITCH_CYC)
      ) u_ch (
        .i_clk           (I_CLK),
        .i_rst           (I_RST),
        .i_on_cmd        (i_channel_on_command[g]),
        .i_on_rise       (on_rise[g]),
        .i_short_win     (i_shortened_window_bit[g]),
        .i_fail_mode     (i_fail_mode),
        .i_blank         (blank_now),
        .i_over_inrush   (s_inrush[g]),
        .i_over_steady   (s_steady[g]),
        .i_warn_hi       (s_whi[g]),
        .i_warn_lo       (s_wlo[g]),
        .i_warn_sel      (i_warning_threshold_select),
        .i_shutdown_temp (s_sd[g]),
        .i_status_read   (i_status_read[g]),
        .o_out_en        (ch_en[g]),
        .o_phase         (ch_phase[2*g +: 2]),
        .o_warn_flag     (ch_warn[g]),
        .o_sd_flag       (ch_sd[g]),
        .o_oc_flag       (ch_oc[g])
      );
    end
  endgenerate

  // -------------------------------------------------------------
  // threshold adjust and registered outputs
  // -------------------------------------------------------------
  // the halving only applies during the off-to-on inrush phase
  reg [NCH-1:0] in_inrush;
  integer k;
  always @* begin
    for (k = 0; k < NCH; k = k + 1)
      in_inrush[k] = (ch_phase[2*k +: 2] != `OFP_PH_IDLE);
  end

  always @(posedge I_CLK) begin
    if (I_RST) begin
      o_out_en                    <= {NCH{1'b0}};
      o_level_one_reduce          <= {NCH{1'b0}};
      o_level_halve               <= {NCH{1'b0}};
      o_phase                     <= {2*NCH{1'b0}};
      o_channel_temp_warning_flag <= {NCH{1'b0}};
      o_thermal_shutdown          <= {NCH{1'b0}};
      o_overcurrent_flag          <= {NCH{1'b0}};
      o_quick_temp_warning        <= 1'b0;
      o_blanking                  <= 1'b0;
    end else begin
      o_out_en                    <= ch_en;
      o_level_one_reduce          <= {NCH{i_thermal_adjust_bit & s_hot}};
      o_level_halve               <= {NCH{i_transient_adjust_bit}} & s_below & in_inrush;
      o_phase                     <= ch_phase;
      o_channel_temp_warning_flag <= ch_warn;
      o_thermal_shutdown          <= ch_sd;
      o_overcurrent_flag          <= ch_oc;
      o_quick_temp_warning        <= |ch_warn;
      o_blanking                  <= blank_now;
    end
  end

endmodule // ofp_top

`default_nettype wire

// File: tb.sv
// self-checking bench for the protection top with its comparator model
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam integer N = 2;
  localparam integer BL = 10;
  localparam integer DG = 4;
  localparam integer RS = 100;
  logic           clk, rst, wake, fail, therm, trans, sel, hot, quick, blank;
  logic [N-1:0]   cmd, shortb, rd, olow, ovi, ovs, whi, wlo, sdt, out_en, red, halve, wflag, sdf, ocf;
  logic [2*N-1:0] ph, load;
  logic [8*N-1:0] temp;
  logic [7:0]     die;
  integer         n_fail, num_checks, n, i, j;
  integer         wl [1:3] = '{20, 40, 80};
  logic [7:0]     wtemp [7] = '{8'h7D, 8'h8C, 8'h8C, 8'h64, 8'h64, 8'h7D, 8'h64};
  logic [6:0]     wrd = 7'h54;
  logic [6:0]     wexp = 7'h2E;
  ofp_afe_model #(.NCH(N)) u_ofp_afe_model (.i_die_temp(die), .i_temp(temp), .i_load(load), .o_die_hot(hot),
    .o_warn_lo(wlo), .o_warn_hi(whi), .o_shutdown_temp(sdt), .o_over_inrush(ovi), .o_over_steady(ovs));
  ofp_top #(.NCH(N), .WIN1_CYC(20), .WIN2_CYC(40), .WIN3_CYC(80), .RESTART_CYC(RS), .BLANK_CYC(BL),
    .DEGLITCH_CYC(DG)) u_ofp_top (.I_CLK(clk), .I_RST(rst), .i_wake(wake), .i_fail_mode(fail),
    .i_thermal_adjust_bit(therm), .i_transient_adjust_bit(trans), .i_warning_threshold_select(sel),
    .i_channel_on_command(cmd), .i_shortened_window_bit(shortb), .i_status_read(rd), .i_die_hot(hot),
    .i_out_below_half(olow), .i_over_inrush(ovi), .i_over_steady(ovs), .i_warn_hi(whi), .i_warn_lo(wlo),
    .i_shutdown_temp(sdt), .o_out_en(out_en), .o_level_one_reduce(red), .o_level_halve(halve), .o_phase(ph),
    .o_channel_temp_warning_flag(wflag), .o_thermal_shutdown(sdf), .o_overcurrent_flag(ocf),
    .o_quick_temp_warning(quick), .o_blanking(blank));
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  // ------------------------------------------------------------
  // helpers; outputs are read at the edge, before its updates land
  // ------------------------------------------------------------
  task automatic tk(input integer c);
    repeat (c) @(posedge clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask
  task automatic summarize;
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #(50 * 5000);
    n_fail = n_fail + 1;
    summarize();
  end
  initial begin
    n_fail = 0;
    num_checks = 0;
    {rst, wake, fail, therm, trans, sel} = 6'h20;
    {cmd, shortb, rd, olow, load} = '0;
    temp = {N{8'h50}};
    die = 8'h30;
    tk(6);
    rst <= 1'h0;
    tk(2);
    chk(out_en, 8'h00, "outputs after reset");
    wake <= 1'h1;
    for (n = 0; n < 40 && blank !== 1'h1; n++) tk(1);
    for (n = 0; n < 400 && blank === 1'h1; n++) tk(1);
    chk(n >= BL && n <= BL + 1, 8'h01, "blanking length");
    for (i = 0; i < 2; i++) begin
      shortb <= {N{i[0]}};
      cmd[0] <= 1'h1;
      for (n = 0; n < 400 && ph[1:0] !== 2'h1; n++) tk(1);
      for (j = 1; j < 4; j++) begin
        for (n = 0; n < 400 && ph[1:0] !== 2'((j + 1) % 4); n++) tk(1);
        chk(n >= (wl[j] >> i) - 1 && n <= (wl[j] >> i) + 1, 8'h01, "window length");
      end
      cmd[0] <= 1'h0;
      tk(3);
    end
    cmd[0] <= 1'h1;
    for (n = 0; n < 400 && ph[1:0] !== 2'h1; n++) tk(1);
    tk(5);
    cmd[0] <= 1'h0;
    tk(30);
    chk(ph[1:0], 8'h01, "window moved while off");
    cmd <= 2'h3;
    for (n = 0; n < 400 && ph[1:0] !== 2'h2; n++) tk(1);
    chk(n >= 12 && n <= 17, 8'h01, "window resume");
    // full-length windows keep channel 0 in inrush through the halving cases
    shortb <= '0;
    for (i = 0; i < 8; i++) begin
      therm <= i[0];
      die <= i[1] ? 8'h50 : 8'h30;
      trans <= i[2];
      olow[0] <= i[1];
      tk(8);
      chk(red[0], i[0] & i[1], "level one cut");
      chk(halve[0], i[2] & i[1], "inrush halving");
    end
    {therm, trans, olow} <= '0;
    for (n = 0; n < 400 && ph[1:0] !== 2'h0; n++) tk(1);
    for (i = 0; i < 7; i++) begin
      sel <= (i >= 5);
      temp[7:0] <= wtemp[i];
      tk(10);
      rd[0] <= wrd[i];
      tk(1);
      rd[0] <= 1'h0;
      tk(6);
      chk(wflag[0], wexp[i], "warning flag");
      chk(quick, wexp[i], "quick warning");
      chk(out_en[0], 8'h01, "output kept on");
    end
    chk(wflag[1], 8'h00, "other channel warning");
    temp[7:0] <= 8'hB4;
    for (n = 0; n < 100 && sdf[0] !== 1'h1; n++) tk(1);
    chk(n >= DG + 3 && n <= DG + 8, 8'h01, "shutdown delay");
    tk(1);
    chk(out_en, 8'h02, "only hot channel off");
    temp[7:0] <= 8'h64;
    fail <= 1'h1;
    load[3:2] <= 2'h1;
    for (n = 0; n < 100 && out_en[1] !== 1'h0; n++) tk(1);
    load[3:2] <= 2'h0;
    for (n = 0; n < 400 && out_en[1] !== 1'h1; n++) tk(1);
    chk(n >= RS - 3 && n <= RS + 3, 8'h01, "restart delay");
    chk(ocf, 8'h02, "overcurrent flag kept");
    summarize();
  end
endmodule // tb
`default_nettype wire
